// ---- hdl/boot_loader_pkg.sv ----
// Constants, types and register map of the boot mode loader
// Overview of operation
// RULE_01: Straps external low, link low, memory-select high choose host boot.
// RULE_02: Host boot waits as bus slave, fetching nothing until download finishes.
// RULE_03: Host boot uses channel 10, packing 8 or 16 bit words into 48 bits.
// RULE_04: Host and link boot load 256 instructions at 0x40000 to 0x400FF before executing.
// RULE_05: After reset the core idles with program counter 0x40004, never executed.
// RULE_06: Host boot presets index 0x40000, count 0x100, control 0x161.
// RULE_07: Host control preset: enabled, low byte first, packing 101, three columns.
// RULE_08: Host requests the bus with request and chip select before transfers.
// RULE_09: After grant and ready the host may write system configuration width.
// RULE_10: Host delivers boot data by writing external port buffer zero.
// RULE_11: Count drops per transfer; at zero stop, raise interrupt, vector 0x40050.
// RULE_12: Straps external low, link high, memory-select high choose link boot.
// RULE_13: Link boot uses channel 8, taking 4-bit data into link buffer zero.
// RULE_14: Sender drives link clock; nibbles are captured on its falling edges.
// RULE_15: Link sender sends each instruction most significant nibble first.
// RULE_16: Link boot presets index 0x40000, count 0x100, buffer zero 48-bit.
// RULE_17: Link buffer zero is always the boot receiver.
// RULE_18: Straps external low, link high, memory-select low choose serial boot.
// RULE_19: Serial boot loads serial control with 0x0A001F81, 32-bit receive.
// RULE_20: Serial boot stores 0x180 32-bit words from 0x40000, then executes.
// RULE_21: Receive shift register gathers 32 bits before each memory write.
// RULE_22: No-boot skips loading, keeps defaults, fetches from 0x200004.
package boot_loader_pkg;

  typedef enum logic [1:0] {
    MODE_NONE   = 2'b00,
    MODE_HOST   = 2'b01,
    MODE_LINK   = 2'b10,
    MODE_SERIAL = 2'b11
  } boot_mode_t;

  typedef enum logic [1:0] {
    ST_SAMPLE = 2'b00,
    ST_LOAD   = 2'b01,
    ST_RUN    = 2'b10
  } boot_state_t;

  // Register byte offsets
  localparam logic [7:0]  OFS_CONTROL   = 8'h00;
  localparam logic [7:0]  OFS_INDEX     = 8'h04;
  localparam logic [7:0]  OFS_COUNT     = 8'h08;
  localparam logic [7:0]  OFS_STATUS    = 8'h0c;
  localparam logic [7:0]  OFS_SYSCONFIG = 8'h10;
  localparam logic [7:0]  OFS_SERIAL    = 8'h14;

  localparam logic [31:0] CONTROL_HOST_RESET = 32'h0000_0161;
  localparam logic [31:0] SERIAL_BOOT_RESET  = 32'h0a00_1f81;
  localparam logic [23:0] BOOT_BASE          = 24'h04_0000;
  localparam logic [23:0] PC_IDLE            = 24'h04_0004;
  localparam logic [23:0] PC_VECTOR          = 24'h04_0050;
  localparam logic [23:0] PC_NO_BOOT         = 24'h20_0004;
  localparam logic [15:0] COUNT_INSTR        = 16'h0100;
  localparam logic [15:0] COUNT_SERIAL       = 16'h0180;
  localparam logic [3:0]  CHANNEL_HOST       = 4'ha;
  localparam logic [3:0]  CHANNEL_LINK       = 4'h8;

  // Field positions
  localparam int CTL_ENABLE_BIT = 0;
  localparam int SYS_WIDE_BIT   = 0;

  // Pieces per memory word
  localparam logic [5:0] PIECES_BYTE   = 6'd6;
  localparam logic [5:0] PIECES_HALF   = 6'd3;
  localparam logic [5:0] PIECES_NIBBLE = 6'd12;
  localparam logic [5:0] PIECES_BIT    = 6'd32;

  // Cycles after reset release before the straps are valid at the filter
  localparam logic [2:0] STRAP_SETTLE = 3'd5;

endpackage : boot_loader_pkg

// ---- hdl/boot_mode_loader.sv ----
// Boot mode loader: strap decode, boot DMA for host, link and serial boot
`timescale 1ns/1ps
module boot_mode_loader
  import boot_loader_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        srst_i,
  input  wire logic        external_boot_strap_i,
  input  wire logic        link_boot_strap_i,
  input  wire logic        boot_memory_select_i,
  input  wire logic        host_bus_request_i,
  input  wire logic        host_cs_i,
  input  wire logic        host_wr_i,
  input  wire logic        host_addr_i,
  input  wire logic [15:0] host_data_i,
  output logic             host_bus_grant_o,
  output logic             host_ready_o,
  input  wire logic        link_clock_i,
  input  wire logic [3:0]  link_data_i,
  input  wire logic        serial_clock_i,
  input  wire logic        serial_select_n_i,
  input  wire logic        serial_data_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic [31:0]      reg_rdata_o,
  output logic             mem_wr_o,
  output logic [23:0]      mem_addr_o,
  output logic [47:0]      mem_data_o,
  output logic             boot_channel_interrupt_o,
  output logic [23:0]      pc_o,
  output logic             core_run_o,
  output logic [1:0]       boot_mode_o
);

  // ==========================================================================
  // Input synchronisers
  // ==========================================================================
  localparam int NSYNC = 14;

  logic [NSYNC-1:0] async_w;
  logic [NSYNC-1:0] s1_reg;
  logic [NSYNC-1:0] s2_reg;
  logic [NSYNC-1:0] s3_reg;
  logic [NSYNC-1:0] filt_reg;
  logic [NSYNC-1:0] filt_next;

  assign async_w = {external_boot_strap_i, link_boot_strap_i, boot_memory_select_i,
                    host_bus_request_i, host_cs_i, host_wr_i, link_clock_i,
                    link_data_i, serial_clock_i, serial_select_n_i, serial_data_i};

  // A change is taken only once stages two and three agree
  // Limitation: each link or serial clock phase must span two core clocks
  genvar g;
  generate
    for (g = 0; g < NSYNC; g++) begin : g_sync
      assign filt_next[g] = (s2_reg[g] == s3_reg[g]) ? s3_reg[g] : filt_reg[g];
    end
  endgenerate

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      s1_reg   <= '0;
      s2_reg   <= '0;
      s3_reg   <= '0;
      filt_reg <= '0;
    end else begin
      s1_reg   <= async_w;
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      filt_reg <= filt_next;
    end
  end

  logic       ext_strap_w;
  logic       lnk_strap_w;
  logic       bms_strap_w;
  logic       hbr_w;
  logic       hcs_w;
  logic       hwr_rise_w;
  logic       lclk_fall_w;
  logic [3:0] lnk_nib_w;
  logic       sclk_rise_w;
  logic       ssel_w;
  logic       sdat_w;

  assign ext_strap_w = filt_reg[13];
  assign lnk_strap_w = filt_reg[12];
  assign bms_strap_w = filt_reg[11];
  assign hbr_w       = filt_reg[10];
  assign hcs_w       = filt_reg[9];
  assign hwr_rise_w  = filt_next[8] & ~filt_reg[8];
  assign lclk_fall_w = ~filt_next[7] & filt_reg[7];   // [RULE_14]
  assign lnk_nib_w   = filt_next[6:3];
  assign sclk_rise_w = filt_next[2] & ~filt_reg[2];
  assign ssel_w      = ~filt_reg[1];
  assign sdat_w      = filt_next[0];

  // ==========================================================================
  // Mode decode
  // ==========================================================================
  function automatic boot_mode_t decode_mode(input logic ext, input logic lnk, input logic boot_memory_select);
    boot_mode_t m;
    m = MODE_NONE;
    if (!ext && !lnk && boot_memory_select)
      m = MODE_HOST;                       // [RULE_01]
    else if (!ext && lnk && boot_memory_select)
      m = MODE_LINK;                       // [RULE_12]
    else if (!ext && lnk && !boot_memory_select)
      m = MODE_SERIAL;                     // [RULE_18]
    return m;
  endfunction : decode_mode

  boot_mode_t  mode_reg;
  boot_state_t state_reg;
  logic [2:0]  settle_reg;
  boot_mode_t  strap_mode_w;

  assign strap_mode_w = decode_mode(ext_strap_w, lnk_strap_w, bms_strap_w);

  // ==========================================================================
  // Channel registers and packing
  // ==========================================================================
  logic [31:0] control_reg;
  logic [31:0] sysconfig_reg;
  logic [31:0] serial_ctl_reg;
  logic [23:0] index_reg;
  logic [15:0] count_reg;
  logic [47:0] pack_reg;
  logic [5:0]  pieces_reg;
  logic        grant_reg;

  logic        loading_w;
  logic        enable_w;
  logic        host_buf_wr_w;
  logic        host_cfg_wr_w;
  logic        piece_w;
  logic [47:0] pack_next;
  logic [5:0]  pieces_full_w;
  logic        word_done_w;
  logic        last_word_w;
  logic        wide_w;

  assign loading_w = (state_reg == ST_LOAD);
  // Host channel honours software enable; link and serial channels always run
  assign enable_w  = (mode_reg != MODE_HOST) | control_reg[CTL_ENABLE_BIT];
  assign wide_w    = sysconfig_reg[SYS_WIDE_BIT];

  // Host data bypass the synchronisers; the host holds them around the strobe
  // Host may only write once grant and ready stand
  assign host_buf_wr_w = loading_w & (mode_reg == MODE_HOST) & grant_reg
                         & hwr_rise_w & ~host_addr_i;                  // [RULE_10] [RULE_08]
  assign host_cfg_wr_w = loading_w & (mode_reg == MODE_HOST) & grant_reg
                         & hwr_rise_w & host_addr_i;                   // [RULE_09]

  // Link data always lands in buffer zero
  assign piece_w = loading_w & enable_w & (
                     host_buf_wr_w
                   | ((mode_reg == MODE_LINK) & lclk_fall_w)           // [RULE_13] [RULE_17]
                   | ((mode_reg == MODE_SERIAL) & ssel_w & sclk_rise_w));

  always_comb begin
    pack_next     = pack_reg;
    pieces_full_w = PIECES_BIT;
    unique case (mode_reg)
      MODE_HOST: begin
        // Low piece first: shift in from the top
        if (wide_w) begin
          pack_next     = {host_data_i, pack_reg[47:16]};             // [RULE_03]
          pieces_full_w = PIECES_HALF;
        end else begin
          pack_next     = {host_data_i[7:0], pack_reg[47:8]};         // [RULE_07]
          pieces_full_w = PIECES_BYTE;
        end
      end
      MODE_LINK: begin
        pack_next     = {pack_reg[43:0], lnk_nib_w};                   // [RULE_15]
        pieces_full_w = PIECES_NIBBLE;
      end
      MODE_SERIAL: begin
        // One bit per serial clock rise, most significant first; 32 bits fill one 32-bit word
        pack_next     = {16'h0000, pack_reg[30:0], sdat_w};            // [RULE_21]
        pieces_full_w = PIECES_BIT;
      end
      MODE_NONE: begin
        pack_next     = pack_reg;
        pieces_full_w = PIECES_BIT;
      end
    endcase
  end

  assign word_done_w = piece_w & (pieces_reg == pieces_full_w - 6'd1);
  assign last_word_w = word_done_w & (count_reg == 16'h0001);          // [RULE_11]

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state_reg  <= ST_SAMPLE;
      mode_reg   <= MODE_NONE;
      settle_reg <= '0;
    end else begin
      unique case (state_reg)
        ST_SAMPLE: begin
          // Straps are read once; later changes wait for the next reset
          settle_reg <= settle_reg + 3'd1;
          if (settle_reg == STRAP_SETTLE) begin
            mode_reg  <= strap_mode_w;
            state_reg <= (strap_mode_w == MODE_NONE) ? ST_RUN : ST_LOAD; // [RULE_22]
          end
        end
        ST_LOAD: begin
          if (last_word_w)
            state_reg <= ST_RUN;                                       // [RULE_04]
        end
        ST_RUN: begin
          state_reg <= ST_RUN;
        end
        default: begin
          state_reg <= ST_SAMPLE;
        end
      endcase
    end
  end

  logic sample_done_w;
  assign sample_done_w = (state_reg == ST_SAMPLE) & (settle_reg == STRAP_SETTLE);

  // Channel parameters: preset per mode once straps are known
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      index_reg      <= '0;
      count_reg      <= '0;
      serial_ctl_reg <= '0;
    end else if (sample_done_w) begin
      unique case (strap_mode_w)
        MODE_HOST: begin
          index_reg <= BOOT_BASE;                                      // [RULE_06]
          count_reg <= COUNT_INSTR;
        end
        MODE_LINK: begin
          index_reg <= BOOT_BASE;                                      // [RULE_16]
          count_reg <= COUNT_INSTR;
        end
        MODE_SERIAL: begin
          index_reg      <= BOOT_BASE;                                 // [RULE_20]
          count_reg      <= COUNT_SERIAL;
          serial_ctl_reg <= SERIAL_BOOT_RESET;                         // [RULE_19]
        end
        MODE_NONE: begin
          index_reg <= '0;                                             // [RULE_22]
          count_reg <= '0;
        end
      endcase
    end else if (word_done_w) begin
      index_reg <= index_reg + 24'd1;
      count_reg <= count_reg - 16'd1;                                  // [RULE_11]
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      pack_reg   <= '0;
      pieces_reg <= '0;
    end else if (piece_w) begin
      pack_reg   <= pack_next;
      pieces_reg <= word_done_w ? 6'd0 : pieces_reg + 6'd1;
    end else if ((mode_reg == MODE_SERIAL) & ~ssel_w) begin
      // A frame cut short by deselect must not shift the next word
      pieces_reg <= '0;
    end
  end

  // Control and configuration registers, bus and host writers
  logic reg_ctl_wr_w;
  logic reg_sys_wr_w;
  assign reg_ctl_wr_w = reg_wr_i & (reg_addr_i == OFS_CONTROL);
  assign reg_sys_wr_w = reg_wr_i & (reg_addr_i == OFS_SYSCONFIG);

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      control_reg   <= '0;
      sysconfig_reg <= '0;
    end else begin
      if (sample_done_w)
        control_reg <= (strap_mode_w == MODE_HOST) ? CONTROL_HOST_RESET : 32'h0000_0000; // [RULE_06] [RULE_07]
      else if (reg_ctl_wr_w)
        control_reg <= reg_wdata_i;
      if (host_cfg_wr_w)
        sysconfig_reg <= {16'h0000, host_data_i};                      // [RULE_09]
      else if (reg_sys_wr_w)
        sysconfig_reg <= reg_wdata_i;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      grant_reg                <= 1'b0;
      host_bus_grant_o         <= 1'b0;
      host_ready_o             <= 1'b0;
      mem_wr_o                 <= 1'b0;
      mem_addr_o               <= '0;
      mem_data_o               <= '0;
      boot_channel_interrupt_o <= 1'b0;
      pc_o                     <= PC_IDLE;                             // [RULE_05]
      core_run_o               <= 1'b0;
      boot_mode_o              <= MODE_NONE;
    end else begin
      // Slave only while loading; grant drops once the kernel is in
      grant_reg                <= loading_w & ~last_word_w & (mode_reg == MODE_HOST)
                                  & hbr_w & hcs_w;                     // [RULE_02] [RULE_08]
      host_bus_grant_o         <= loading_w & ~last_word_w & (mode_reg == MODE_HOST)
                                  & hbr_w & hcs_w;
      host_ready_o             <= loading_w & ~last_word_w & (mode_reg == MODE_HOST)
                                  & hbr_w & hcs_w;
      mem_wr_o                 <= word_done_w;
      if (word_done_w) begin
        mem_addr_o <= index_reg;
        mem_data_o <= pack_next;
      end
      // Completion vectors to the interrupt; no-boot jumps to external code
      boot_channel_interrupt_o <= last_word_w;                         // [RULE_11]
      if (last_word_w) begin
        pc_o       <= PC_VECTOR;                                       // [RULE_11]
        core_run_o <= 1'b1;                                            // [RULE_04]
      end else if (sample_done_w && strap_mode_w == MODE_NONE) begin
        pc_o       <= PC_NO_BOOT;                                      // [RULE_22]
        core_run_o <= 1'b1;
      end
      if (sample_done_w)
        boot_mode_o <= strap_mode_w;
    end
  end

  // ==========================================================================
  // Register read port
  // ==========================================================================
  logic [3:0]  channel_w;
  logic [31:0] status_w;
  logic [31:0] rdata_w;

  assign channel_w = (mode_reg == MODE_HOST) ? CHANNEL_HOST :
                     (mode_reg == MODE_NONE) ? 4'h0 : CHANNEL_LINK;
  assign status_w  = {24'h000000, channel_w, 1'b0, mode_reg, (state_reg == ST_RUN)};

  // Index, count, status and serial control are read-only
  always_comb begin
    unique case (reg_addr_i)
      OFS_CONTROL:   rdata_w = control_reg;
      OFS_INDEX:     rdata_w = {8'h00, index_reg};
      OFS_COUNT:     rdata_w = {16'h0000, count_reg};
      OFS_STATUS:    rdata_w = status_w;
      OFS_SYSCONFIG: rdata_w = sysconfig_reg;
      OFS_SERIAL:    rdata_w = serial_ctl_reg;
      default:       rdata_w = 32'h0000_0000;
    endcase
  end

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge clock_i) begin
    if (srst_i)
      reg_rdata_o <= '0;
    else
      reg_rdata_o <= reg_rd_i ? rdata_w : 32'h0000_0000;
  end

endmodule : boot_mode_loader

// ---- testbench/boot_mode_loader_asserts.sv ----
// Port-level assertions for the boot mode loader
`timescale 1ns/1ps
module boot_mode_loader_asserts
  import boot_loader_pkg::*;
(
  input wire logic        clock_i,
  input wire logic        srst_i,
  input wire logic        host_bus_request_i,
  input wire logic        host_cs_i,
  input wire logic        host_bus_grant_o,
  input wire logic        host_ready_o,
  input wire logic        mem_wr_o,
  input wire logic [23:0] mem_addr_o,
  input wire logic        boot_channel_interrupt_o,
  input wire logic [23:0] pc_o,
  input wire logic        core_run_o,
  input wire logic [1:0]  boot_mode_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);

  // ==========================================
  // Properties
  property p_reset_idle;
    $fell(srst_i) |-> pc_o == PC_IDLE && !core_run_o && !mem_wr_o;
  endproperty
  property p_ready_grant;
    host_ready_o == host_bus_grant_o;
  endproperty
  property p_grant_host;
    host_bus_grant_o |-> boot_mode_o == MODE_HOST;
  endproperty
  property p_grant_req;
    $rose(host_bus_grant_o) |-> $past(host_bus_request_i, 2) && $past(host_cs_i, 2);
  endproperty
  // Request raised once the straps are decoded, and held until grant
  property p_grant_time;
    $rose(host_bus_request_i && host_cs_i) && boot_mode_o == MODE_HOST && !core_run_o
      |-> ##[1:8] host_bus_grant_o;
  endproperty
  property p_irq_pulse;
    boot_channel_interrupt_o |=> !boot_channel_interrupt_o && !host_bus_grant_o;
  endproperty
  property p_irq_wake;
    boot_channel_interrupt_o |-> mem_wr_o && pc_o == PC_VECTOR && core_run_o;
  endproperty
  property p_run_after_load;
    $rose(core_run_o) |-> boot_channel_interrupt_o || boot_mode_o == MODE_NONE;
  endproperty
  // Serial words are 32 bits, so their addresses run past the kernel range
  property p_mem_range;
    mem_wr_o && boot_mode_o != MODE_SERIAL |-> mem_addr_o >= BOOT_BASE && mem_addr_o <= 24'h0400ff;
  endproperty
  property p_pc_idle;
    !core_run_o && boot_mode_o != MODE_NONE |-> pc_o == PC_IDLE;
  endproperty

  // ==========================================
  // Assertions and covers
  a_reset_idle: assert property (p_reset_idle) else $error("pc or run wrong after reset");
  a_ready_grant: assert property (p_ready_grant) else $error("ready differs from grant");
  a_grant_host: assert property (p_grant_host) else $error("grant outside host boot");
  a_grant_req: assert property (p_grant_req) else $error("grant without request");
  a_grant_time: assert property (p_grant_time) else $error("grant late");
  a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt not a pulse");
  a_irq_wake: assert property (p_irq_wake) else $error("no vector at completion");
  a_run_after_load: assert property (p_run_after_load) else $error("run before load");
  a_mem_range: assert property (p_mem_range) else $error("write outside kernel");
  a_pc_idle: assert property (p_pc_idle) else $error("pc moved while loading");
  c_grant: cover property ($rose(host_bus_grant_o));
  c_irq: cover property (boot_channel_interrupt_o);
  c_link: cover property (mem_wr_o && boot_mode_o == MODE_LINK);
endmodule : boot_mode_loader_asserts

bind boot_mode_loader boot_mode_loader_asserts chk_i (
  .clock_i(clock_i), .srst_i(srst_i), .host_bus_request_i(host_bus_request_i), .host_cs_i(host_cs_i),
  .host_bus_grant_o(host_bus_grant_o), .host_ready_o(host_ready_o), .mem_wr_o(mem_wr_o),
  .mem_addr_o(mem_addr_o), .boot_channel_interrupt_o(boot_channel_interrupt_o), .pc_o(pc_o),
  .core_run_o(core_run_o), .boot_mode_o(boot_mode_o)
);

// ---- testbench/link_sender.sv ----
// Link port sender model: one boot word per request
`timescale 1ns/1ps
module link_sender (
  input  wire logic        send_i,
  input  wire logic [47:0] word_i,
  output logic             done_o,
  output logic             link_clock_o,
  output logic [3:0]       link_data_o
);
  initial begin
    done_o = 1'b0;
    link_clock_o = 1'b1;
    link_data_o = 4'h0;
  end
  // Clock stands high between words; offset keeps edges off the core clock
  always @(posedge send_i) begin
    done_o = 1'b0;
    #3;
    for (int i = 11; i >= 0; i--) begin
      link_data_o = word_i[i*4 +: 4];
      #80 link_clock_o = 1'b0;
      #80 link_clock_o = 1'b1;
    end
    // Stale nibble must not look valid after the word
    link_data_o = ~link_data_o;
    done_o = 1'b1;
  end
endmodule : link_sender

// ---- testbench/test_boot_mode_loader.sv ----
// Self-checking bench of the boot mode loader
`timescale 1ns/1ps
module test_boot_mode_loader
  import boot_loader_pkg::*;
;
  logic        clock_i = 1'b0;
  logic        srst_i = 1'b1;
  logic        ext = 1'b0;
  logic        lnk = 1'b0;
  logic        boot_memory_select = 1'b1;
  logic        hreq = 1'b0;
  logic        hcs = 1'b0;
  logic        hwr = 1'b0;
  logic        haddr = 1'b0;
  logic [15:0] hdata = 16'h0000;
  logic [7:0]  raddr = 8'h00;
  logic [31:0] rwdata = 32'h0;
  logic        rwr = 1'b0;
  logic        rrd = 1'b0;
  logic [47:0] lword = 48'h0;
  logic        lsend = 1'b0;
  logic        sclk = 1'b0;
  logic        ssel_n = 1'b1;
  logic        sdat = 1'b0;
  logic        ldone, lclk, grant, ready, mem_wr, irq, run;
  logic [3:0]  ldat;
  logic [31:0] rdata;
  logic [23:0] mem_addr, pc;
  logic [47:0] mem_data;
  logic [1:0]  mode;
  int          failures = 0;
  int          check_count = 0;
  int          words = 0;
  int          irqs = 0;

  always #5 clock_i = ~clock_i;

  boot_mode_loader uut (
    .clock_i(clock_i), .srst_i(srst_i), .external_boot_strap_i(ext), .link_boot_strap_i(lnk),
    .boot_memory_select_i(boot_memory_select), .host_bus_request_i(hreq), .host_cs_i(hcs), .host_wr_i(hwr),
    .host_addr_i(haddr), .host_data_i(hdata), .host_bus_grant_o(grant), .host_ready_o(ready),
    .link_clock_i(lclk), .link_data_i(ldat), .serial_clock_i(sclk), .serial_select_n_i(ssel_n),
    .serial_data_i(sdat), .reg_addr_i(raddr), .reg_wdata_i(rwdata), .reg_wr_i(rwr), .reg_rd_i(rrd),
    .reg_rdata_o(rdata), .mem_wr_o(mem_wr), .mem_addr_o(mem_addr), .mem_data_o(mem_data),
    .boot_channel_interrupt_o(irq), .pc_o(pc), .core_run_o(run), .boot_mode_o(mode)
  );
  // Sender wired to buffer zero, the only boot receiver
  link_sender partner (.send_i(lsend), .word_i(lword), .done_o(ldone), .link_clock_o(lclk),
    .link_data_o(ldat));

  // ==========================================
  // Helpers
  function automatic logic [47:0] pat(input int n);
    return {16'h1234 ^ 16'(n), 16'hbe0f, 16'(n)};
  endfunction : pat
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic stall();
    failures++;
    results();
  endtask : stall
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask : cyc
  task automatic boot(input logic [2:0] s);
    @(posedge clock_i);
    {ext, lnk, boot_memory_select} <= s;
    srst_i <= 1'b1;
    cyc(5);
    srst_i <= 1'b0;
    words = 0;
    irqs = 0;
    cyc(10);
  endtask : boot
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock_i);
    raddr <= a;
    rrd <= 1'b1;
    @(posedge clock_i);
    rrd <= 1'b0;
    @(posedge clock_i);
    chk(48'(rdata), 48'(e));
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    raddr <= a;
    rwdata <= d;
    rwr <= 1'b1;
    @(posedge clock_i);
    rwr <= 1'b0;
  endtask : wr
  // Data settles well before the strobe since it is not synchronised
  task automatic hput(input logic a, input logic [15:0] d);
    haddr <= a;
    hdata <= d;
    cyc(6);
    hwr <= 1'b1;
    cyc(4);
    hwr <= 1'b0;
    cyc(6);
  endtask : hput
  task automatic send(input logic [47:0] w);
    lword <= w;
    lsend <= 1'b1;
    cyc(1);
    lsend <= 1'b0;
    for (int i = 0; i < 300 && ldone !== 1'b1; i++) cyc(1);
    if (ldone !== 1'b1) stall();
  endtask : send

  always @(posedge clock_i) begin
    if (!srst_i && mem_wr === 1'b1) begin
      chk(48'(mem_addr), 48'(BOOT_BASE) + 48'(words));
      chk(mem_data, pat(words) & {{16{mode != MODE_SERIAL}}, 32'hffff_ffff});
      words++;
    end
    if (!srst_i && irq === 1'b1) irqs++;
  end

  // ==========================================
  // Scenarios
  task automatic t_host();
    logic [47:0] w;
    boot(3'b001);
    chk(48'(mode), 48'(MODE_HOST));
    chk(48'(pc), 48'(PC_IDLE));
    rd(OFS_CONTROL, CONTROL_HOST_RESET);
    rd(OFS_INDEX, 32'(BOOT_BASE));
    rd(OFS_COUNT, 32'(COUNT_INSTR));
    rd(OFS_STATUS, 32'h0000_00a2);
    wr(OFS_INDEX, 32'h0000_0123);
    rd(OFS_INDEX, 32'(BOOT_BASE));
    rd(8'hfc, 32'h0);
    chk(48'(run), 48'h0);
    hreq <= 1'b1;
    hcs <= 1'b1;
    for (int i = 0; i < 20 && grant !== 1'b1; i++) cyc(1);
    if (grant !== 1'b1) stall();
    chk(48'(ready), 48'h1);
    w = pat(0);
    for (int k = 0; k < 6; k++) hput(1'b0, {8'hff, w[k*8 +: 8]});
    hput(1'b1, 16'h0001);
    rd(OFS_SYSCONFIG, 32'h1);
    for (int n = 1; n < 256; n++) begin
      w = pat(n);
      for (int k = 0; k < 3; k++) hput(1'b0, w[k*16 +: 16]);
    end
    chk(48'(words), 48'd256);
    chk(48'(irqs), 48'd1);
    chk(48'(pc), 48'(PC_VECTOR));
    chk(48'(run), 48'h1);
    chk(48'(grant), 48'h0);
    hreq <= 1'b0;
    hcs <= 1'b0;
    rd(OFS_COUNT, 32'h0);
    $display("host boot test done");
  endtask : t_host
  task automatic t_link();
    boot(3'b011);
    chk(48'(mode), 48'(MODE_LINK));
    rd(OFS_STATUS, 32'h0000_0084);
    rd(OFS_INDEX, 32'(BOOT_BASE));
    rd(OFS_COUNT, 32'(COUNT_INSTR));
    for (int n = 0; n < 256; n++) send(pat(n));
    cyc(8);
    chk(48'(words), 48'd256);
    chk(48'(irqs), 48'd1);
    chk(48'(pc), 48'(PC_VECTOR));
    chk(48'(run), 48'h1);
    $display("link boot test done");
  endtask : t_link
  task automatic t_serial();
    logic [47:0] w;
    boot(3'b010);
    chk(48'(mode), 48'(MODE_SERIAL));
    rd(OFS_SERIAL, SERIAL_BOOT_RESET);
    rd(OFS_COUNT, 32'(COUNT_SERIAL));
    rd(OFS_STATUS, 32'h0000_0086);
    hreq <= 1'b1;
    hcs <= 1'b1;
    cyc(12);
    chk(48'(grant), 48'h0);
    hreq <= 1'b0;
    hcs <= 1'b0;
    w = pat(0);
    ssel_n <= 1'b0;
    for (int b = 31; b >= 0; b--) begin
      sdat <= w[b];
      cyc(4);
      sclk <= 1'b1;
      cyc(4);
      sclk <= 1'b0;
    end
    cyc(8);
    ssel_n <= 1'b1;
    chk(48'(words), 48'd1);
    $display("serial boot test done");
  endtask : t_serial
  task automatic t_none();
    boot(3'b000);
    chk(48'(mode), 48'(MODE_NONE));
    chk(48'(pc), 48'(PC_NO_BOOT));
    rd(OFS_CONTROL, 32'h0);
    cyc(20);
    chk(48'(words), 48'd0);
    $display("no boot test done");
  endtask : t_none

  initial begin
    t_host();
    t_link();
    t_serial();
    t_none();
    results();
  end
endmodule : test_boot_mode_loader
